// ---- pwm_pkg.sv ----
// Register map, field positions and reset values of the pulse generator
package pwm_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_INT_CTL = 8'h0B;
    localparam logic [7:0] IDX_FLAGS_ONE = 8'h0C;
    localparam logic [7:0] IDX_FLAGS_TWO = 8'h0D;
    localparam logic [7:0] IDX_BASE_CNT = 8'h11;
    localparam logic [7:0] IDX_BASE_CTL = 8'h12;
    localparam logic [7:0] IDX_U1_DUTY_LOW = 8'h15;
    localparam logic [7:0] IDX_U1_DUTY_SLAVE = 8'h16;
    localparam logic [7:0] IDX_U1_MODE = 8'h17;
    localparam logic [7:0] IDX_U2_DUTY_LOW = 8'h1B;
    localparam logic [7:0] IDX_U2_DUTY_SLAVE = 8'h1C;
    localparam logic [7:0] IDX_U2_MODE = 8'h1D;
    localparam logic [7:0] IDX_PORT_C_DIR = 8'h87;
    localparam logic [7:0] IDX_ENABLES_ONE = 8'h8C;
    localparam logic [7:0] IDX_ENABLES_TWO = 8'h8D;
    localparam logic [7:0] IDX_PERIOD = 8'h92;
    // Reset values
    localparam logic [7:0] RST_PERIOD = 8'hFF;
    localparam logic [7:0] RST_BASE_CNT = 8'h00;
    localparam logic [7:0] RST_PORT_C_DIR = 8'hFF;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // Field positions
    localparam int MATCH_FLAG_BIT = 1;
    localparam int UNIT_ONE_FLAG_BIT = 2;
    localparam int UNIT_TWO_FLAG_BIT = 0;
    localparam int RUN_BIT = 2;
    localparam int POSTSCALE_LSB = 3;
    localparam int FRACTION_LSB = 4;
    localparam int UNIT_ONE_PIN_BIT = 2;
    localparam int UNIT_TWO_PIN_BIT = 1;
    // Mode field values
    localparam logic [1:0] MODE_PWM_TOP = 2'h3;
    localparam logic [3:0] MODE_OFF = 4'h0;
    // Oscillator cycles per instruction cycle, and prescale terminal counts
    localparam int OSC_PER_INSTR = 4;
    localparam logic [3:0] PRESC_MAX_1 = 4'h0;
    localparam logic [3:0] PRESC_MAX_4 = 4'h3;
    localparam logic [3:0] PRESC_MAX_16 = 4'hF;
    localparam logic [1:0] LAST_PHASE = 2'(OSC_PER_INSTR - 1);
endpackage

// ---- pwm_duty_unit.sv ----
// One capture/compare/PWM unit in PWM mode: duty double buffer and pin latch
module pwm_duty_unit
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic pwm_mode,
    input wire logic [9:0] duty_value,
    input wire logic period_end,
    input wire logic [9:0] count_value,
    input wire logic slave_we,
    input wire logic [7:0] slave_wdata,
    output logic [7:0] duty_slave,
    output logic pwm_out
);
    import pwm_pkg::*;

    logic [1:0] slave_frac;
    logic period_start;
    wire logic [9:0] slave_value = {duty_slave, slave_frac};
    wire logic duty_match = slave_value == count_value;

    // No reset on the buffer: its content is undefined until the first period end or a write while the unit is off
    always_ff @(posedge core_clk)
    begin
        if (clk_en)
        begin
            if (pwm_mode && period_end)
            begin
                duty_slave <= duty_value[9:2];
                slave_frac <= duty_value[1:0];
            end
            else if (!pwm_mode && slave_we)
            begin
                duty_slave <= slave_wdata;
            end
        end
    end

    // Set one clock after the latch, as the clear also lags its match
    // by one clock: high time is then exactly duty steps
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            period_start <= 1'b0;
            pwm_out <= 1'b0;
        end
        else if (clk_en)
        begin
            period_start <= pwm_mode && period_end;
            if (!pwm_mode)
                pwm_out <= 1'b0;
            else if (period_start)
                pwm_out <= slave_value != 10'h000;
            else if (duty_match)
                pwm_out <= 1'b0;
        end
    end

    // ==================================================================
    // Checks
    AST_SLAVE_LOCKED: assert property (@(posedge core_clk) disable iff (!rstn)
        pwm_mode && !period_end && clk_en |=> $stable(duty_slave))
        else $error("Duty slave changed outside period end");
    AST_MATCH_CLEARS: assert property (@(posedge core_clk) disable iff (!rstn)
        clk_en && pwm_mode && !period_start && duty_match |=> !pwm_out)
        else $error("Output not cleared on duty match");
    AST_OFF_LOW: assert property (@(posedge core_clk) disable iff (!rstn)
        clk_en && !pwm_mode |=> !pwm_out)
        else $error("Output high while unit off");
    AST_PERIOD_SET: assert property (@(posedge core_clk) disable iff (!rstn)
        clk_en && pwm_mode && period_start |=>
        pwm_out == ($past(slave_value) != 10'h000))
        else $error("Period start did not set output");
    AST_PERIOD_LATCH: assert property (@(posedge core_clk) disable iff (!rstn)
        clk_en && pwm_mode && period_end |=>
        slave_value == $past(duty_value))
        else $error("Period end did not latch duty");
    AST_FULL_DUTY: assert property (@(posedge core_clk) disable iff (!rstn)
        pwm_out && pwm_mode && slave_value > {count_value[9:2], 2'h3}
        && !period_end ##1 pwm_mode && clk_en |-> pwm_out)
        else $error("Output dropped before duty reached");
endmodule

// ---- pwm_period_duty_generator.sv ----
// Pulse-width modulator top: AHB-Lite registers, base counter, two units
//
// Design decision made here: the AHB-Lite register port.
module pwm_period_duty_generator
#(
    parameter bit HAS_UNIT_TWO = 1'b1
)
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic unit_one_pin_out,
    output logic unit_one_pin_oe,
    output logic unit_two_pin_out,
    output logic unit_two_pin_oe,
    output logic irq
);
    import pwm_pkg::*;

    // ==================================================================
    // Bus slave
    logic wr_pend;
    logic rd_pend;
    logic [7:0] bus_idx;
    logic bus_ok;
    logic [31:0] rd_word;

    // Only whole words are decoded: a transfer of another size is ignored
    wire logic addr_phase = hsel && hready && htrans[1];
    wire logic addr_ok = haddr[31:10] == 22'h0 && haddr[1:0] == 2'h0
        && hsize == 3'h2;
    wire logic [7:0] wdata = hwdata[7:0];
    wire logic wr_go = wr_pend && bus_ok;

    wire logic wr_int_ctl = wr_go && bus_idx == IDX_INT_CTL;
    wire logic wr_flags_one = wr_go && bus_idx == IDX_FLAGS_ONE;
    wire logic wr_flags_two = wr_go && bus_idx == IDX_FLAGS_TWO;
    wire logic wr_base_cnt = wr_go && bus_idx == IDX_BASE_CNT;
    wire logic wr_base_ctl = wr_go && bus_idx == IDX_BASE_CTL;
    wire logic wr_port_dir = wr_go && bus_idx == IDX_PORT_C_DIR;
    wire logic wr_en_one = wr_go && bus_idx == IDX_ENABLES_ONE;
    wire logic wr_en_two = wr_go && bus_idx == IDX_ENABLES_TWO;
    wire logic wr_period = wr_go && bus_idx == IDX_PERIOD;
    wire logic [1:0] wr_duty_low;
    wire logic [1:0] wr_slave;
    wire logic [1:0] wr_mode;
    assign wr_duty_low[0] = wr_go && bus_idx == IDX_U1_DUTY_LOW;
    assign wr_duty_low[1] = wr_go && bus_idx == IDX_U2_DUTY_LOW;
    assign wr_slave[0] = wr_go && bus_idx == IDX_U1_DUTY_SLAVE;
    assign wr_slave[1] = wr_go && bus_idx == IDX_U2_DUTY_SLAVE;
    assign wr_mode[0] = wr_go && bus_idx == IDX_U1_MODE;
    assign wr_mode[1] = wr_go && bus_idx == IDX_U2_MODE;

    // Reads insert one wait state so a write just ahead is seen
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            bus_idx <= 8'h00;
            bus_ok <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            wr_pend <= addr_phase && hwrite;
            rd_pend <= addr_phase && !hwrite;
            if (addr_phase)
            begin
                bus_idx <= haddr[9:2];
                bus_ok <= addr_ok;
            end
            hreadyout <= !(addr_phase && !hwrite);
            if (rd_pend)
                hrdata <= rd_word;
        end
    end

    // ==================================================================
    // Registers
    logic [7:0] int_ctl;
    logic [7:0] flags_one;
    logic flags_two;
    logic [7:0] base_counter;
    logic [6:0] base_ctl;
    logic [7:0] port_dir;
    logic [7:0] enables_one;
    logic enables_two;
    logic [7:0] period_limit;
    logic [7:0] duty_low [2];
    logic [5:0] mode_ctl [2];
    logic [7:0] duty_slave [2];
    logic [1:0] pin_state;
    logic match_event;

    wire logic [1:0] prescale_select = base_ctl[1:0];
    wire logic base_counter_run = base_ctl[RUN_BIT];
    wire logic [3:0] postscale_select = base_ctl[POSTSCALE_LSB +: 4];

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            int_ctl <= RST_ZERO;
            base_ctl <= 7'h00;
            port_dir <= RST_PORT_C_DIR;
            enables_one <= RST_ZERO;
            enables_two <= 1'b0;
            period_limit <= RST_PERIOD;
        end
        else if (clk_en)
        begin
            if (wr_int_ctl)
                int_ctl <= wdata;
            if (wr_base_ctl)
                base_ctl <= wdata[6:0];
            if (wr_port_dir)
                port_dir <= wdata;
            if (wr_en_one)
                enables_one <= wdata;
            if (wr_en_two)
                enables_two <= HAS_UNIT_TWO && wdata[0];
            if (wr_period)
                period_limit <= wdata;
        end
    end

    // Duty low registers have no reset value by design
    always_ff @(posedge core_clk)
    begin
        if (clk_en)
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (wr_duty_low[i])
                    duty_low[i] <= wdata;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mode_ctl[0] <= 6'h00;
            mode_ctl[1] <= 6'h00;
        end
        else if (clk_en)
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (wr_mode[i])
                    mode_ctl[i] <= wdata[5:0];
            end
        end
    end

    // ==================================================================
    // Base counter and prescaler
    logic [1:0] q_phase;
    logic [3:0] presc_cnt;
    logic [3:0] post_cnt;
    logic [3:0] presc_max;
    logic [1:0] frac;

    assign presc_max = prescale_select == 2'h0 ? PRESC_MAX_1 :
        prescale_select == 2'h1 ? PRESC_MAX_4 : PRESC_MAX_16;
    // Fraction steps once per prescaled oscillator period
    assign frac = prescale_select == 2'h0 ? q_phase :
        prescale_select == 2'h1 ? presc_cnt[1:0] : presc_cnt[3:2];
    wire logic instr_end = q_phase == LAST_PHASE;
    wire logic inc = base_counter_run && instr_end
        && presc_cnt == presc_max;
    wire logic period_end = inc && base_counter == period_limit;
    wire logic [9:0] count_value = {base_counter, frac};
    wire logic post_done = post_cnt == postscale_select;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            q_phase <= 2'h0;
            presc_cnt <= 4'h0;
            post_cnt <= 4'h0;
            base_counter <= RST_BASE_CNT;
            match_event <= 1'b0;
        end
        else if (clk_en)
        begin
            q_phase <= q_phase + 2'h1;
            match_event <= period_end && post_done;
            if (wr_base_cnt || wr_base_ctl)
                presc_cnt <= 4'h0;
            else if (base_counter_run && instr_end)
                presc_cnt <= inc ? 4'h0 : presc_cnt + 4'h1;
            if (wr_base_cnt)
                base_counter <= wdata;
            else if (period_end)
                base_counter <= 8'h00;
            else if (inc)
                base_counter <= base_counter + 8'h01;
            if (wr_base_ctl)
                post_cnt <= 4'h0;
            else if (period_end)
                post_cnt <= post_done ? 4'h0 : post_cnt + 4'h1;
        end
    end

    // ==================================================================
    // Duty units
    for (genvar u = 0; u < 2; u++)
    begin : g_unit
        wire logic pwm_mode = mode_ctl[u][3:2] == MODE_PWM_TOP;
        wire logic [9:0] duty_value =
            {duty_low[u], mode_ctl[u][FRACTION_LSB +: 2]};
        pwm_duty_unit unit
        (
            .core_clk(core_clk),
            .rstn(rstn),
            .clk_en(clk_en),
            .pwm_mode(pwm_mode),
            .duty_value(duty_value),
            .period_end(period_end),
            .count_value(count_value),
            .slave_we(wr_slave[u]),
            .slave_wdata(wdata),
            .duty_slave(duty_slave[u]),
            .pwm_out(pin_state[u])
        );
    end

    // ==================================================================
    // Interrupts and pins
    wire logic [7:0] flags_two_view = {7'h00, HAS_UNIT_TWO && flags_two};
    wire logic [7:0] enables_two_view = {7'h00, enables_two};

    // Hardware set wins over a write-one clear in the same cycle
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            flags_one <= RST_ZERO;
            flags_two <= 1'b0;
            irq <= 1'b0;
            unit_one_pin_out <= 1'b0;
            unit_one_pin_oe <= 1'b0;
            unit_two_pin_out <= 1'b0;
            unit_two_pin_oe <= 1'b0;
        end
        else if (clk_en)
        begin
            flags_one <= (flags_one & ~(wr_flags_one ? wdata : 8'h00))
                | {6'h00, match_event, 1'b0};
            if (wr_flags_two && wdata[0])
                flags_two <= 1'b0;
            irq <= |(flags_one & enables_one)
                || (flags_two_view[0] && enables_two_view[0]);
            unit_one_pin_out <= pin_state[0];
            unit_one_pin_oe <= !port_dir[UNIT_ONE_PIN_BIT];
            unit_two_pin_out <= pin_state[1];
            unit_two_pin_oe <= !port_dir[UNIT_TWO_PIN_BIT];
        end
    end

    // ==================================================================
    // Read mux
    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (bus_ok)
        begin
            case (bus_idx)
                IDX_INT_CTL: rd_word[7:0] = int_ctl;
                IDX_FLAGS_ONE: rd_word[7:0] = flags_one;
                IDX_FLAGS_TWO: rd_word[7:0] = flags_two_view;
                IDX_BASE_CNT: rd_word[7:0] = base_counter;
                IDX_BASE_CTL: rd_word[7:0] = {1'b0, base_ctl};
                IDX_U1_DUTY_LOW: rd_word[7:0] = duty_low[0];
                IDX_U1_DUTY_SLAVE: rd_word[7:0] = duty_slave[0];
                IDX_U1_MODE: rd_word[7:0] = {2'h0, mode_ctl[0]};
                IDX_U2_DUTY_LOW: rd_word[7:0] = duty_low[1];
                IDX_U2_DUTY_SLAVE: rd_word[7:0] = duty_slave[1];
                IDX_U2_MODE: rd_word[7:0] = {2'h0, mode_ctl[1]};
                IDX_PORT_C_DIR: rd_word[7:0] = port_dir;
                IDX_ENABLES_ONE: rd_word[7:0] = enables_one;
                IDX_ENABLES_TWO: rd_word[7:0] = enables_two_view;
                IDX_PERIOD: rd_word[7:0] = period_limit;
                default: rd_word = 32'h0000_0000;
            endcase
        end
    end

    // ==================================================================
    // Checks
    AST_RESET_VALUES: assert property (@(posedge core_clk)
        $rose(rstn) |-> period_limit == RST_PERIOD
        && base_counter == RST_BASE_CNT)
        else $error("Period or counter wrong after reset");
    AST_PERIOD_WRAP: assert property (@(posedge core_clk) disable iff (!rstn)
        clk_en && period_end && !wr_base_cnt |=> base_counter == 8'h00)
        else $error("Counter not cleared at period end");
    AST_INSTR_CYCLE: assert property (@(posedge core_clk) disable iff (!rstn)
        clk_en && inc && !period_end && !wr_base_cnt |=>
        base_counter == $past(base_counter) + 8'h01)
        else $error("Counter did not advance by one");
    AST_PRESCALE_ONE: assert property (@(posedge core_clk) disable iff (!rstn)
        clk_en && inc && prescale_select == 2'h0 |=> !inc [*3])
        else $error("Prescale one advanced too soon");
    AST_FRACTION_STEPS: assert property (@(posedge core_clk) disable iff (!rstn)
        inc |-> frac == 2'h3)
        else $error("Fraction not at last step on increment");
    AST_NO_UNIT_TWO: assert property (@(posedge core_clk) disable iff (!rstn)
        !HAS_UNIT_TWO |-> flags_two_view == 8'h00
        && (!enables_two || !clk_en))
        else $error("Missing unit two bits not zero");
    AST_DUTY_FORM: assert property (@(posedge core_clk) disable iff (!rstn)
        clk_en && period_end && g_unit[0].pwm_mode |=>
        duty_slave[0] == $past(duty_low[0]))
        else $error("Duty slave not loaded from low register");
endmodule

// ---- pwm_load_model.sv ----
// Load on the pulse pin: measures high time and period of each pulse
module pwm_load_model
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic meas_valid,
    output logic [15:0] meas_high,
    output logic [15:0] meas_period
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // Pin level
    logic level;
    logic last;
    logic seen_rise;
    logic [15:0] hi_cnt;
    logic [15:0] per_cnt;
    // Pull-down on the load: a released pin reads low, never the last value
    assign level = pin_oe ? pin_out : 1'b0;
    // ==========================================
    // Measurement, one result per rising edge after the first
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            last <= 1'b0;
            seen_rise <= 1'b0;
            hi_cnt <= 16'h0000;
            per_cnt <= 16'h0000;
            meas_valid <= 1'b0;
            meas_high <= 16'h0000;
            meas_period <= 16'h0000;
        end
        else
        begin
            last <= level;
            meas_valid <= level && !last && seen_rise;
            if (level && !last)
            begin
                meas_high <= hi_cnt;
                meas_period <= per_cnt;
                hi_cnt <= 16'h0001;
                per_cnt <= 16'h0001;
                seen_rise <= 1'b1;
            end
            else
            begin
                hi_cnt <= hi_cnt + 16'(level);
                per_cnt <= per_cnt + 16'h0001;
            end
        end
    end
endmodule

// ---- tb_top.sv ----
// Self-checking bench of the pulse generator with register bus driver
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import pwm_pkg::*;
    // ==========================================
    // Signals
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    logic pin_out;
    logic pin_oe;
    logic irq;
    logic meas_valid;
    logic [15:0] meas_high;
    logic [15:0] meas_period;
    logic [31:0] exp_rd_q[$];
    logic [31:0] exp_pw_q[$];
    logic [31:0] rd_val;
    int rd_count = 0;
    int rd_seen = 0;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 6;
    always #50 core_clk = ~core_clk;
    pwm_period_duty_generator u_pwm_period_duty_generator (
        .core_clk(core_clk), .rstn(rstn), .clk_en(1'b1), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .unit_one_pin_out(pin_out),
        .unit_one_pin_oe(pin_oe), .unit_two_pin_out(),
        .unit_two_pin_oe(), .irq(irq));
    pwm_load_model u_pwm_load_model (
        .core_clk(core_clk), .rstn(rstn), .pin_out(pin_out),
        .pin_oe(pin_oe), .meas_valid(meas_valid),
        .meas_high(meas_high), .meas_period(meas_period));
    // ==========================================
    // Checking
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Watcher takes the oldest note whenever a result appears
    always @(posedge core_clk)
    begin
        if (rd_count != rd_seen && exp_rd_q.size() > 0)
        begin
            rd_seen = rd_count;
            check(rd_val, exp_rd_q.pop_front());
        end
        if (meas_valid && exp_pw_q.size() > 0)
            check({meas_high, meas_period}, exp_pw_q.pop_front());
    end
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            bad_count++;
            print_verdict();
        end
    end
    // ==========================================
    // Bus master: single word transfers, waits on hready
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd, input logic [7:0] er);
        if (!wr)
            exp_rd_q.push_back({24'h0, er});
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge core_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge core_clk); while (hready !== 1'b1);
        if (!wr)
        begin
            rd_val = hrdata;
            rd_count++;
        end
    endtask
    // Pulse run in the documented set-up order
    task automatic run_pwm(input logic [7:0] lim, input logic [1:0] ps,
                           input logic [9:0] duty);
        int pre;
        int per;
        int hi;
        pre = (ps == 2'h0) ? 1 : (ps == 2'h1) ? 4 : 16;
        per = (int'(lim) + 1) * OSC_PER_INSTR * pre;
        hi = 0;
        // Stopped counter restarts at zero, so no long wrap past the limit
        bus(1'b1, IDX_BASE_CTL, 8'h00, 8'h00);
        bus(1'b1, IDX_BASE_CNT, 8'h00, 8'h00);
        bus(1'b1, IDX_PERIOD, lim, 8'h00);
        bus(1'b1, IDX_U1_DUTY_LOW, duty[9:2], 8'h00);
        bus(1'b1, IDX_PORT_C_DIR, 8'hFB, 8'h00);
        bus(1'b1, IDX_BASE_CTL, {5'h00, 1'b1, ps}, 8'h00);
        bus(1'b1, IDX_U1_MODE, {2'h0, duty[1:0], 4'hC}, 8'h00);
        repeat (3 * per) @(posedge core_clk);
        if (duty != 10'h000 && int'(duty) < per / pre)
        begin
            exp_pw_q.push_back({16'(int'(duty) * pre), 16'(per)});
            wait (exp_pw_q.size() == 0);
        end
        else
        begin
            repeat (per)
            begin
                @(posedge core_clk);
                hi += int'(pin_out === 1'b1);
            end
            check(32'(hi), (duty == 10'h000) ? 32'h0 : 32'(per));
        end
        bus(1'b1, IDX_U1_DUTY_SLAVE, 8'h55, 8'h00);
        bus(1'b0, IDX_U1_DUTY_SLAVE, 8'h00, duty[9:2]);
        bus(1'b0, IDX_U1_MODE, 8'h00, {2'h0, duty[1:0], 4'hC});
    endtask
    // ==========================================
    // Main sequence
    logic [7:0] rst_tab[7][2] = '{'{IDX_PERIOD, RST_PERIOD},
        '{IDX_BASE_CNT, RST_BASE_CNT}, '{IDX_BASE_CTL, RST_ZERO},
        '{IDX_U1_MODE, RST_ZERO}, '{IDX_PORT_C_DIR, RST_PORT_C_DIR},
        '{IDX_FLAGS_ONE, RST_ZERO}, '{8'h40, 8'h00}};
    initial
    begin
        logic [7:0] lim;
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        foreach (rst_tab[i])
            bus(1'b0, rst_tab[i][0], 8'h00, rst_tab[i][1]);
        // Slave buffer has no reset: load it while the unit is off
        bus(1'b1, IDX_U1_DUTY_SLAVE, 8'h5A, 8'h00);
        bus(1'b0, IDX_U1_DUTY_SLAVE, 8'h00, 8'h5A);
        $display("test reset values done");
        run_pwm(8'h3F, 2'h0, 10'h0FF);
        run_pwm(8'h3F, 2'h0, 10'h100);
        run_pwm(8'h03, 2'h0, 10'h000);
        for (int i = 0; i < 6; i++)
        begin
            lim = 8'($unsigned($random(seed)) % 8);
            run_pwm(lim, 2'(i % 3),
                    10'(1 + $unsigned($random(seed)) % (4 * lim + 3)));
        end
        $display("test pulse shapes done");
        bus(1'b1, IDX_ENABLES_ONE, 8'h02, 8'h00);
        repeat (100) @(posedge core_clk);
        bus(1'b0, IDX_FLAGS_ONE, 8'h00, 8'h02);
        check(32'(irq), 32'h1);
        bus(1'b1, IDX_ENABLES_ONE, 8'h00, 8'h00);
        repeat (2) @(posedge core_clk);
        check(32'(irq), 32'h0);
        bus(1'b1, IDX_BASE_CTL, 8'h00, 8'h00);
        bus(1'b1, IDX_FLAGS_ONE, 8'h02, 8'h00);
        bus(1'b0, IDX_FLAGS_ONE, 8'h00, 8'h00);
        bus(1'b1, IDX_ENABLES_ONE, 8'h02, 8'h00);
        repeat (2) @(posedge core_clk);
        check(32'(irq), 32'h0);
        $display("test interrupt done");
        bus(1'b1, IDX_U1_MODE, {4'h0, MODE_OFF}, 8'h00);
        repeat (4) @(posedge core_clk);
        check(32'(pin_out), 32'h0);
        run_pwm(8'h02, 2'h0, 10'h005);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        check(32'(pin_out), 32'h0);
        for (int i = 0; i < 4; i++)
            bus(1'b0, rst_tab[i][0], 8'h00, rst_tab[i][1]);
        $display("test second reset done");
        repeat (4) @(posedge core_clk);
        print_verdict();
    end
endmodule
